// ===== common/sbba_pkg.sv
// constants and types for the serial bus byte access engine
// Notes on behaviour
// - a read sets direction one; software polls busy until clear, then data is valid
// - the data register is the byte sent on writes and receives the read byte
// - the index register is sent as the byte address on reads and writes
// - the target device address comes from bits seven to one
// - direction bit zero requests a byte write, one a byte read
// - the direction bit is sent as the read/write bit after the address
// - data, index and address registers clear only on global reset
// - writing the address register sets busy; completion clears it with data present
// - a missing acknowledge sets a sticky error flag, cleared by writing one
// - short protocol select uses send/receive byte and omits the index byte
// - serial clock about 100 kHz, faster when the test bit is set
package sbba_pkg;
  localparam logic [7:0] OFS_DATA = 8'hb0;
  localparam logic [7:0] OFS_INDEX = 8'hb1;
  localparam logic [7:0] OFS_ADDR = 8'hb2;
  localparam logic [7:0] OFS_CTL = 8'hb3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int BIT_PROT = 7;
  localparam int BIT_BUSY = 5;
  localparam int BIT_FAST = 2;
  localparam int BIT_ERR = 1;
  localparam int BIT_DIR = 0;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned SCL_NORMAL_HZ = 100000;
  localparam int unsigned SCL_FAST_HZ = 400000;
  // four quarter phases per serial bit, rounded up so the clock never runs fast
  localparam logic [7:0] QTR_NORMAL = 8'((CLK_HZ + 4 * SCL_NORMAL_HZ - 1) / (4 * SCL_NORMAL_HZ));
  localparam logic [7:0] QTR_FAST = 8'((CLK_HZ + 4 * SCL_FAST_HZ - 1) / (4 * SCL_FAST_HZ));

  typedef enum logic [1:0] {
    CMD_START = 2'h0,
    CMD_STOP = 2'h1,
    CMD_WR = 2'h2,
    CMD_RD = 2'h3
  } sbba_bitcmd_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sbba_cfg_req_s;
endpackage

// ===== verilog/sbba_bit_engine.sv
// one serial bus bit, start or stop condition in four quarter phases
`timescale 1ns/100ps
`default_nettype none
module sbba_bit_engine (
  // clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // command
  input wire logic go_i,
  input wire sbba_pkg::sbba_bitcmd_e cmd_i,
  input wire logic tx_bit_i,
  input wire logic fast_i,
  // synchronised pin levels
  input wire logic scl_sync_i,
  input wire logic sda_sync_i,
  // status
  output logic busy_o,
  output logic done_o,
  output logic rx_bit_o,
  // pin enables, low drives the line low
  output logic scl_oen_o,
  output logic sda_oen_o
);
  logic busy_q, busy_d, done_q, done_d, rx_q, rx_d, tx_q, tx_d;
  logic scl_oen_q, scl_oen_d, sda_oen_q, sda_oen_d;
  logic [1:0] ph_q, ph_d;
  logic [7:0] cnt_q, cnt_d, qtr;
  sbba_pkg::sbba_bitcmd_e cmd_q, cmd_d;
  logic [1:0] drv;

  // returns {scl_low, sda_low} for a phase
  function automatic logic [1:0] drive(sbba_pkg::sbba_bitcmd_e c, logic [1:0] p, logic t);
    logic sl;
    logic dl;
    sl = (p == 2'h0) || (p == 2'h3);
    dl = 1'b0;
    case (c)
      sbba_pkg::CMD_START: dl = p[1];
      sbba_pkg::CMD_STOP: begin
        sl = (p == 2'h0);
        dl = (p != 2'h3);
      end
      sbba_pkg::CMD_WR: dl = !t;
      default: dl = 1'b0;
    endcase
    return {sl, dl};
  endfunction

  always_comb begin
    qtr = fast_i ? sbba_pkg::QTR_FAST : sbba_pkg::QTR_NORMAL;
    busy_d = busy_q;
    done_d = 1'b0;
    rx_d = rx_q;
    tx_d = tx_q;
    cmd_d = cmd_q;
    ph_d = ph_q;
    cnt_d = cnt_q;
    drv = drive(cmd_q, ph_q, tx_q);
    scl_oen_d = busy_q ? !drv[1] : scl_oen_q;
    sda_oen_d = busy_q ? !drv[0] : sda_oen_q;
    if (!busy_q) begin
      if (go_i) begin
        busy_d = 1'b1;
        cmd_d = cmd_i;
        tx_d = tx_bit_i;
        ph_d = 2'h0;
        cnt_d = qtr;
      end
    end else if (!(scl_oen_q && !scl_sync_i)) begin
      // a target holding the clock low stretches the high phase
      if (cnt_q <= 8'h01) begin
        cnt_d = qtr;
        if (ph_q == 2'h2) begin
          rx_d = sda_sync_i;
        end
        if (ph_q == 2'h3) begin
          busy_d = 1'b0;
          done_d = 1'b1;
        end else begin
          ph_d = ph_q + 2'h1;
        end
      end else begin
        cnt_d = cnt_q - 8'h01;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rx_q <= 1'b0;
      tx_q <= 1'b0;
      cmd_q <= sbba_pkg::CMD_START;
      ph_q <= 2'h0;
      cnt_q <= 8'h00;
      scl_oen_q <= 1'b1;
      sda_oen_q <= 1'b1;
    end else begin
      busy_q <= busy_d;
      done_q <= done_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      cmd_q <= cmd_d;
      ph_q <= ph_d;
      cnt_q <= cnt_d;
      scl_oen_q <= scl_oen_d;
      sda_oen_q <= sda_oen_d;
    end
  end

  assign busy_o = busy_q;
  assign done_o = done_q;
  assign rx_bit_o = rx_q;
  assign scl_oen_o = scl_oen_q;
  assign sda_oen_o = sda_oen_q;
endmodule
`default_nettype wire

// ===== verilog/sbba_top.sv
// register set and byte sequencer of the serial bus byte access engine
`timescale 1ns/100ps
`default_nettype none
module sbba_top (
  // clock and resets
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic global_reset_i,
  // configuration access
  input wire sbba_pkg::sbba_cfg_req_s cfg_req_i,
  output logic [7:0] cfg_rdata_o,
  // serial clock pin
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oen_o,
  // serial data pin
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oen_o
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_ADDR = 3'h2,
    ST_INDEX = 3'h3,
    ST_WDATA = 3'h4,
    ST_RDATA = 3'h5,
    ST_STOP = 3'h6
  } sbba_state_e;

  logic scl_meta_q, scl_sync_q, sda_meta_q, sda_sync_q;
  logic [7:0] data_q, data_d, index_q, index_d, addr_q, addr_d;
  logic prot_q, prot_d, fast_q, fast_d, err_q, err_d;
  logic busy_q, busy_d, second_q, second_d, dir_q, dir_d, go_q, go_d;
  logic [7:0] shift_q, shift_d, rdata_q, rdata_d;
  logic [3:0] bitcnt_q, bitcnt_d;
  sbba_state_e state_q, state_d;
  sbba_pkg::sbba_bitcmd_e cmd;
  logic tx_bit, eng_busy, eng_done, eng_rx, eng_reset, start_req, wr_bytes, err_set;

  assign eng_reset = reset_i | global_reset_i;

  sbba_bit_engine u_bit (
    .clock_i(clock_i),
    .reset_i(eng_reset),
    .go_i(go_q),
    .cmd_i(cmd),
    .tx_bit_i(tx_bit),
    .fast_i(fast_q),
    .scl_sync_i(scl_sync_q),
    .sda_sync_i(sda_sync_q),
    .busy_o(eng_busy),
    .done_o(eng_done),
    .rx_bit_o(eng_rx),
    .scl_oen_o(scl_oen_o),
    .sda_oen_o(sda_oen_o)
  );

  // byte phase: bits 0..7 then the acknowledge slot at count 8
  always_comb begin
    wr_bytes = (state_q == ST_ADDR) || (state_q == ST_INDEX) || (state_q == ST_WDATA);
    cmd = sbba_pkg::CMD_RD;
    tx_bit = 1'b1;
    if (state_q == ST_START) begin
      cmd = sbba_pkg::CMD_START;
    end else if (state_q == ST_STOP) begin
      cmd = sbba_pkg::CMD_STOP;
    end else if (wr_bytes) begin
      cmd = bitcnt_q[3] ? sbba_pkg::CMD_RD : sbba_pkg::CMD_WR;
      tx_bit = shift_q[7];
    end else if (bitcnt_q[3]) begin
      cmd = sbba_pkg::CMD_WR;
      tx_bit = 1'b1;
    end
  end

  always_comb begin
    start_req = cfg_req_i.wr && (cfg_req_i.addr == sbba_pkg::OFS_ADDR) && !busy_q;
    data_d = data_q;
    index_d = index_q;
    addr_d = addr_q;
    prot_d = prot_q;
    fast_d = fast_q;
    busy_d = busy_q;
    state_d = state_q;
    bitcnt_d = bitcnt_q;
    shift_d = shift_q;
    second_d = second_q;
    dir_d = dir_q;
    err_set = 1'b0;
    rdata_d = rdata_q;
    go_d = (state_q != ST_IDLE) && !eng_busy && !eng_done && !go_q;
    // host register writes other than the error clear are ignored while a request runs so the transfer stays coherent
    if (cfg_req_i.wr && !busy_q) begin
      if (cfg_req_i.addr == sbba_pkg::OFS_DATA) begin
        data_d = cfg_req_i.wdata;
      end else if (cfg_req_i.addr == sbba_pkg::OFS_INDEX) begin
        index_d = cfg_req_i.wdata;
      end else if (cfg_req_i.addr == sbba_pkg::OFS_ADDR) begin
        addr_d = cfg_req_i.wdata;
      end else if (cfg_req_i.addr == sbba_pkg::OFS_CTL) begin
        prot_d = cfg_req_i.wdata[sbba_pkg::BIT_PROT];
        fast_d = cfg_req_i.wdata[sbba_pkg::BIT_FAST];
      end
    end
    if (start_req) begin
      busy_d = 1'b1;
      state_d = ST_START;
      second_d = 1'b0;
    end
    if (eng_done) begin
      case (state_q)
        ST_START: begin
          state_d = ST_ADDR;
          bitcnt_d = 4'h0;
          // long reads send the address with write first, the read form after the restart
          dir_d = (prot_q || second_q) & addr_q[sbba_pkg::BIT_DIR];
          shift_d = {addr_q[7:1], (prot_q || second_q) & addr_q[sbba_pkg::BIT_DIR]};
        end
        ST_ADDR, ST_INDEX, ST_WDATA: begin
          if (!bitcnt_q[3]) begin
            shift_d = {shift_q[6:0], 1'b0};
            bitcnt_d = bitcnt_q + 4'h1;
          end else begin
            bitcnt_d = 4'h0;
            if (eng_rx) begin
              err_set = 1'b1;
              state_d = ST_STOP;
            end else if (state_q == ST_ADDR && dir_q) begin
              state_d = ST_RDATA;
            end else if (state_q == ST_ADDR && !prot_q) begin
              state_d = ST_INDEX;
              shift_d = index_q;
            end else if (state_q == ST_WDATA) begin
              state_d = ST_STOP;
            end else if (addr_q[sbba_pkg::BIT_DIR]) begin
              state_d = ST_START;
              second_d = 1'b1;
            end else begin
              state_d = ST_WDATA;
              shift_d = data_q;
            end
          end
        end
        ST_RDATA: begin
          if (!bitcnt_q[3]) begin
            shift_d = {shift_q[6:0], eng_rx};
            bitcnt_d = bitcnt_q + 4'h1;
            if (bitcnt_q == 4'h7) begin
              data_d = {shift_q[6:0], eng_rx};
            end
          end else begin
            state_d = ST_STOP;
          end
        end
        ST_STOP: begin
          state_d = ST_IDLE;
          busy_d = 1'b0;
        end
        default: state_d = ST_IDLE;
      endcase
    end
    // a new error wins over a clear in the same cycle
    err_d = err_q;
    if (cfg_req_i.wr && cfg_req_i.addr == sbba_pkg::OFS_CTL && cfg_req_i.wdata[sbba_pkg::BIT_ERR]) begin
      err_d = 1'b0;
    end
    if (err_set) begin
      err_d = 1'b1;
    end
    if (cfg_req_i.rd) begin
      if (cfg_req_i.addr == sbba_pkg::OFS_DATA) begin
        rdata_d = data_q;
      end else if (cfg_req_i.addr == sbba_pkg::OFS_INDEX) begin
        rdata_d = index_q;
      end else if (cfg_req_i.addr == sbba_pkg::OFS_ADDR) begin
        rdata_d = addr_q;
      end else if (cfg_req_i.addr == sbba_pkg::OFS_CTL) begin
        rdata_d = 8'h00;
        rdata_d[sbba_pkg::BIT_PROT] = prot_q;
        rdata_d[sbba_pkg::BIT_BUSY] = busy_q;
        rdata_d[sbba_pkg::BIT_FAST] = fast_q;
        rdata_d[sbba_pkg::BIT_ERR] = err_q;
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  // register contents survive the host reset
  always_ff @(posedge clock_i) begin
    if (global_reset_i) begin
      data_q <= sbba_pkg::RST_BYTE;
      index_q <= sbba_pkg::RST_BYTE;
      addr_q <= sbba_pkg::RST_BYTE;
      prot_q <= 1'b0;
      fast_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      data_q <= data_d;
      index_q <= index_d;
      addr_q <= addr_d;
      prot_q <= prot_d;
      fast_q <= fast_d;
      err_q <= err_d;
    end
  end

  always_ff @(posedge clock_i) begin
    if (eng_reset) begin
      busy_q <= 1'b0;
      state_q <= ST_IDLE;
      bitcnt_q <= 4'h0;
      shift_q <= 8'h00;
      second_q <= 1'b0;
      dir_q <= 1'b0;
      go_q <= 1'b0;
      rdata_q <= 8'h00;
      scl_meta_q <= 1'b1;
      scl_sync_q <= 1'b1;
      sda_meta_q <= 1'b1;
      sda_sync_q <= 1'b1;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      busy_q <= busy_d;
      state_q <= state_d;
      bitcnt_q <= bitcnt_d;
      shift_q <= shift_d;
      second_q <= second_d;
      dir_q <= dir_d;
      go_q <= go_d;
      rdata_q <= rdata_d;
      scl_meta_q <= scl_i;
      scl_sync_q <= scl_meta_q;
      sda_meta_q <= sda_i;
      sda_sync_q <= sda_meta_q;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
    end
  end

  assign cfg_rdata_o = rdata_q;
endmodule
`default_nettype wire

// ===== verification/sbba_props.sv
// checker for the serial bus byte access engine ports
`timescale 1ns/100ps
`default_nettype none
module sbba_props (
  // clock and resets
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic global_reset_i,
  // configuration access
  input wire sbba_pkg::sbba_cfg_req_s cfg_req_i,
  input wire logic [7:0] cfg_rdata_o,
  // serial pins
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oen_o,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oen_o
);
  logic clean_q, seen_q, scl_q, sda_q;
  logic [7:0] hi_q, quiet_q;
  wire logic rd = cfg_req_i.rd;
  wire logic [7:0] a = cfg_req_i.addr;
  wire logic w2 = cfg_req_i.wr && a == 8'hb2;
  wire logic rst = reset_i || global_reset_i;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst);
  always_ff @(posedge clock_i) begin
    scl_q <= scl_oen_o;
    sda_q <= sda_oen_o;
    if (global_reset_i) clean_q <= 1'b1;
    else if (cfg_req_i.wr && a inside {[8'hb0:8'hb2]}) clean_q <= 1'b0;
    if (rst) seen_q <= 1'b0;
    else if (w2) seen_q <= 1'b1;
    // a stop marks the next fall as ending an idle span, not a bit
    if (rst || (scl_q && scl_oen_o && sda_oen_o && !sda_q)) hi_q <= 8'hff;
    else if (!scl_oen_o) hi_q <= 8'h00;
    else if (hi_q != 8'hff) hi_q <= hi_q + 8'h01;
    if (rst || !scl_oen_o || !sda_oen_o) quiet_q <= 8'h00;
    else if (quiet_q != 8'hff) quiet_q <= quiet_q + 8'h01;
  end
  a_reset_idles_pins: assert property (@(posedge clock_i) disable iff (1'b0) rst |=> scl_oen_o && sda_oen_o)
    else $error("pins not released after reset");
  a_unmapped_zero: assert property (rd && !(a inside {[8'hb0:8'hb3]}) |=> cfg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_ctl_spare_zero: assert property (rd && a == 8'hb3 |=> (cfg_rdata_o & 8'h59) == 8'h00)
    else $error("spare status bits not zero");
  a_rdata_holds: assert property (!rd |=> $stable(cfg_rdata_o))
    else $error("read data moved without a read");
  a_global_clear: assert property (clean_q && rd && a inside {[8'hb0:8'hb2]} |=> cfg_rdata_o == 8'h00)
    else $error("register not clear after global reset");
  a_no_unasked_traffic: assert property (!seen_q |-> scl_oen_o && sda_oen_o)
    else $error("bus traffic without request");
  a_request_starts: assert property (w2 && quiet_q > 8'd100 |-> ##[1:40] !scl_oen_o)
    else $error("request did not start traffic");
  a_scl_high_span: assert property ($fell(scl_oen_o) |-> hi_q inside {[8'd12:8'd20], [8'd48:8'd56], 8'hff})
    else $error("serial clock high time wrong");
  c_busy_seen: cover property (rd && a == 8'hb3 ##1 cfg_rdata_o[5]);
  c_error_seen: cover property (rd && a == 8'hb3 ##1 cfg_rdata_o[1]);
  c_fast_bit: cover property ($fell(scl_oen_o) && hi_q < 8'd30);
endmodule
bind sbba_top sbba_props chk (.clock_i(clock_i), .reset_i(reset_i), .global_reset_i(global_reset_i),
  .cfg_req_i(cfg_req_i), .cfg_rdata_o(cfg_rdata_o), .scl_i(scl_i), .scl_o(scl_o), .scl_oen_o(scl_oen_o),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oen_o(sda_oen_o));
`default_nettype wire

// ===== verification/sbba_target.sv
// behavioural serial bus target with a byte memory
`timescale 1ns/100ps
`default_nettype none
module sbba_target #(
  parameter logic [6:0] DEV = 7'h50
) (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_oen_o
);
  logic [7:0] mem [256];
  logic [7:0] sh, ptr;
  logic act = 1'b0;
  logic rd = 1'b0;
  logic hit;
  int n, k;
  initial sda_oen_o = 1'b1;
  // the start's own clock fall is not a bit, hence minus one
  always @(negedge sda_i) if (scl_i) begin
    act = 1'b1;
    n = -1;
    k = 0;
  end
  always @(posedge sda_i) if (scl_i) act = 1'b0;
  always @(posedge scl_i) if (act) sh = {sh[6:0], sda_i};
  always @(negedge scl_i) if (act) begin
    n = n + 1;
    sda_oen_o = 1'b1;
    if (n == 9) begin
      n = 0;
      k = k + 1;
    end
    if (n == 8 && !(rd && k > 0)) begin
      if (k == 0) begin
        hit = sh[7:1] == DEV;
        rd = sh[0];
      end else if (k == 1) ptr = sh;
      else mem[ptr] = sh;
      sda_oen_o = !hit;
    end
    if (rd && k == 1 && n < 8) sda_oen_o = mem[ptr][7 - n];
  end
endmodule
`default_nettype wire

// ===== verification/tb.sv
// bench for the serial bus byte access engine
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam logic [6:0] DEV = 7'h50;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic g_rst = 1'b1;
  sbba_pkg::sbba_cfg_req_s req = '0;
  logic [7:0] rdat, v;
  logic scl_o, scl_oen, sda_o, sda_oen, t_oen;
  wire scl = scl_oen | scl_o;
  wire sda = (sda_oen | sda_o) & t_oen;
  int err_count = 0;
  int checks = 0;
  always #50 clock_i = ~clock_i;
  sbba_top dut (.clock_i(clock_i), .reset_i(reset_i), .global_reset_i(g_rst), .cfg_req_i(req),
    .cfg_rdata_o(rdat), .scl_i(scl), .scl_o(scl_o), .scl_oen_o(scl_oen), .sda_i(sda), .sda_o(sda_o),
    .sda_oen_o(sda_oen));
  sbba_target #(.DEV(DEV)) tgt (.scl_i(scl), .sda_i(sda), .sda_oen_o(t_oen));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clock_i);
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clock_i);
    req <= '0;
    #1 v = rdat;
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    checks++;
    if (v !== e) begin
      err_count++;
      $display("Error reg %h expected %h seen %h", a, e, v);
    end
  endtask
  // bounded poll, a hung request falls through to the next compare
  task automatic idle;
    v = 8'h20;
    for (int i = 0; i < 5000 && v[5] !== 1'b0; i++) rd(8'hb3);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #6000000;
    err_count++;
    $display("Error watchdog expected end seen timeout");
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge clock_i);
    reset_i <= 1'b0;
    g_rst <= 1'b0;
    for (int i = 0; i < 4; i++) chk(8'hb0 + 8'(i), 8'h00);
    wr(8'hb5, 8'hff);
    chk(8'hb5, 8'h00);
    $display("reset test done");
    wr(8'hb0, 8'h5a);
    wr(8'hb1, 8'h10);
    wr(8'hb2, {DEV, 1'b0});
    chk(8'hb3, 8'h20);
    idle();
    chk(8'hb3, 8'h00);
    $display("write test done");
    wr(8'hb0, 8'h00);
    wr(8'hb2, {DEV, 1'b1});
    idle();
    chk(8'hb0, 8'h5a);
    $display("read test done");
    wr(8'hb2, {~DEV, 1'b0});
    idle();
    chk(8'hb3, 8'h02);
    chk(8'hb0, 8'h5a);
    wr(8'hb3, 8'h02);
    chk(8'hb3, 8'h00);
    $display("error test done");
    wr(8'hb1, 8'h77);
    @(posedge clock_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    chk(8'hb1, 8'h77);
    chk(8'hb2, {~DEV, 1'b0});
    $display("host reset test done");
    wr(8'hb3, 8'h84);
    chk(8'hb3, 8'h84);
    // send byte only: the target takes it as its pointer, so a stray index would move the read below
    wr(8'hb0, 8'h10);
    wr(8'hb2, {DEV, 1'b0});
    idle();
    chk(8'hb3, 8'h84);
    wr(8'hb0, 8'h00);
    wr(8'hb2, {DEV, 1'b1});
    idle();
    chk(8'hb3, 8'h84);
    chk(8'hb0, 8'h5a);
    $display("short read test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
